// ===== pps_pkg.sv
// Purpose: constants for the shared pad multiplexer (pin map, register map)
// Assumes: five ports of up to eight pins, flat pad index = port*8 + bit
// Notes: port order is e, f, g, h, i; missing bits read as zero
package pps_pkg;
  // pad array geometry
  localparam int NUM_PORTS = 5;
  localparam int PORT_BITS = 8;
  localparam int NUM_PADS = NUM_PORTS * PORT_BITS;
  localparam int HADDR_W = 12;

  // register byte offsets: data and direction interleaved, then pin levels
  localparam logic [11:0] OFS_DATA0 = 12'h000;
  localparam logic [11:0] OFS_DIR0 = 12'h004;
  localparam logic [11:0] OFS_PORT_STRIDE = 12'h008;
  localparam logic [11:0] OFS_PIN0 = 12'h028;
  localparam logic [11:0] OFS_PIN_STRIDE = 12'h004;

  // reset values and the read value of unmapped offsets
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // implemented bits per port (e:4, f:8, g:6, h:8, i:8)
  localparam logic [39:0] PAD_EXISTS = 40'hff_ff_3f_ff_0f;
  // pads whose input path is gated while in hardware standby
  localparam logic [39:0] STBY_GATED = 40'h01_69_09_00_0f;

  // pad positions of the shared functions
  localparam logic [2:0][5:0] PN_XFER_REQ = {6'h18, 6'h13, 6'h10};
  localparam logic [2:0][5:0] PN_XFER_ACK = {6'h19, 6'h14, 6'h11};
  localparam logic [2:0][5:0] PN_XFER_END = {6'h1a, 6'h15, 6'h12};
  localparam logic [5:0] PN_CONV_TRIG = 6'h00;
  localparam logic [5:0] PN_PULSE_TRIG0 = 6'h01;
  localparam logic [5:0] PN_EXT_IRQ0 = 6'h08;
  localparam logic [5:0] PN_SER_RX = 6'h1b;
  localparam logic [5:0] PN_SER_TX = 6'h1c;
  localparam logic [5:0] PN_SER_CLK = 6'h1d;
  localparam logic [1:0][5:0] PN_TIMER_IN = {6'h20, 6'h1e};
  localparam logic [1:0][5:0] PN_TIMER_OUT = {6'h21, 6'h1f};
  localparam logic [5:0] PN_PULSE_OUT0 = 6'h22;

  // counts of shared functions
  localparam int NUM_XFER_CH = 3;
  localparam int NUM_EXT_IRQ = 8;
  localparam int NUM_TIMERS = 2;
  localparam int NUM_PULSE = 6;
  localparam int NUM_PULSE_TRIG = 3;
endpackage

// ===== pps_pin_mux.sv
// Purpose: shared pad multiplexer between port bits and peripheral functions
// Assumes: pads and peripheral signals are synchronous to sys_clk
// Notes: ahb-lite slave, zero wait state, always OKAY, word accesses only
//
// How it works
// R01 - each transfer channel's acknowledge pad carries the ack while enabled.
// R02 - each transfer channel's end pad carries the end signal while enabled.
// R03 - the serial data pad is driven by the serial unit when enabled.
// R04 - the serial clock pad drives the clock only when enabled, else input.
// R05 - each reload timer output pad carries the timer output when enabled.
// R06 - each of six pulse pads carries its waveform when enabled.
// R07 - a peripheral output wins over the port on the same pad.
// R08 - a transfer request input sees its pad whenever selected as trigger, outside hardware standby.
// R09 - each of eight interrupt inputs sees its pad whenever enabled.
// R10 - the converter trigger input sees its pad whenever selected, outside hardware standby.
// R11 - the serial receive input sees its pad while receiving, outside hardware standby.
// R12 - each reload timer input sees its pad whenever enabled, outside hardware standby.
// R13 - standby gates inputs of standby-controlled pads, not the others.
// R14 - a port-mode pad follows its port's direction and data bits.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module pps_pin_mux (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [pps_pkg::HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pads
  input wire logic [pps_pkg::NUM_PADS-1:0] pad_in,
  output logic [pps_pkg::NUM_PADS-1:0] pad_out,
  output logic [pps_pkg::NUM_PADS-1:0] pad_oe,
  // standby, low while the device is in hardware standby
  input wire logic hw_standby_in_n,
  // transfer engine
  input wire logic [pps_pkg::NUM_XFER_CH-1:0] xfer_ack_out,
  input wire logic [pps_pkg::NUM_XFER_CH-1:0] xfer_ack_out_en,
  input wire logic [pps_pkg::NUM_XFER_CH-1:0] xfer_end_out,
  input wire logic [pps_pkg::NUM_XFER_CH-1:0] xfer_end_out_en,
  input wire logic [pps_pkg::NUM_XFER_CH-1:0] xfer_req_sel,
  output logic [pps_pkg::NUM_XFER_CH-1:0] xfer_req_in,
  // serial unit
  input wire logic ser_tx_data,
  input wire logic ser_tx_en,
  input wire logic ser_clk_out,
  input wire logic ser_clk_out_en,
  input wire logic ser_rx_active,
  output logic ser_rx_data,
  output logic ser_clk_in,
  // reload timers
  input wire logic [pps_pkg::NUM_TIMERS-1:0] reload_timer_out,
  input wire logic [pps_pkg::NUM_TIMERS-1:0] reload_timer_out_en,
  input wire logic [pps_pkg::NUM_TIMERS-1:0] reload_timer_in_en,
  output logic [pps_pkg::NUM_TIMERS-1:0] reload_timer_in,
  // pulse generator
  input wire logic [pps_pkg::NUM_PULSE-1:0] pulse_gen_out,
  input wire logic [pps_pkg::NUM_PULSE-1:0] pulse_gen_out_en,
  output logic [pps_pkg::NUM_PULSE_TRIG-1:0] pulse_gen_trig_in,
  // converter and external interrupts
  input wire logic converter_ext_trigger_sel,
  output logic converter_ext_trigger,
  input wire logic [pps_pkg::NUM_EXT_IRQ-1:0] ext_irq_en,
  output logic [pps_pkg::NUM_EXT_IRQ-1:0] ext_irq_in
);
  import pps_pkg::*;

  typedef struct packed {
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] port_data;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] port_dir;
    logic [NUM_PADS-1:0] pin;
    logic [NUM_PADS-1:0] pad_out;
    logic [NUM_PADS-1:0] pad_oe;
    logic [31:0] hrdata;
    logic hreadyout;
    logic wr_pend;
    logic [HADDR_W-1:0] wr_addr;
    logic [NUM_XFER_CH-1:0] xfer_req;
    logic ser_rx;
    logic ser_clk;
    logic [NUM_TIMERS-1:0] tmr_in;
    logic [NUM_PULSE_TRIG-1:0] ptrig;
    logic conv_trig;
    logic [NUM_EXT_IRQ-1:0] irq;
  } pps_state_t;

  pps_state_t cur_ff;
  pps_state_t nxt_state;

  logic [NUM_PADS-1:0] periph_oe;
  logic [NUM_PADS-1:0] periph_val;
  logic [NUM_PADS-1:0] pad_gated;
  logic in_standby;

  // peripheral claims on each pad
  always_comb begin
    periph_oe = '0;
    periph_val = '0;
    for (int c = 0; c < NUM_XFER_CH; c++) begin
      periph_oe[PN_XFER_ACK[c]] = xfer_ack_out_en[c]; // [R01]
      periph_val[PN_XFER_ACK[c]] = xfer_ack_out[c]; // [R01]
      periph_oe[PN_XFER_END[c]] = xfer_end_out_en[c]; // [R02]
      periph_val[PN_XFER_END[c]] = xfer_end_out[c]; // [R02]
    end
    periph_oe[PN_SER_TX] = ser_tx_en; // [R03]
    periph_val[PN_SER_TX] = ser_tx_data; // [R03]
    periph_oe[PN_SER_CLK] = ser_clk_out_en; // [R04]
    periph_val[PN_SER_CLK] = ser_clk_out; // [R04]
    for (int t = 0; t < NUM_TIMERS; t++) begin
      periph_oe[PN_TIMER_OUT[t]] = reload_timer_out_en[t]; // [R05]
      periph_val[PN_TIMER_OUT[t]] = reload_timer_out[t]; // [R05]
    end
    for (int p = 0; p < NUM_PULSE; p++) begin
      periph_oe[PN_PULSE_OUT0 + 6'(p)] = pulse_gen_out_en[p]; // [R06]
      periph_val[PN_PULSE_OUT0 + 6'(p)] = pulse_gen_out[p]; // [R06]
    end
  end

  // standby gating of the input paths
  assign in_standby = ~hw_standby_in_n;
  assign pad_gated = pad_in & PAD_EXISTS
    & ~({NUM_PADS{in_standby}} & STBY_GATED); // [R13]

  // next state: bus, port registers, pad drive, input routing
  always_comb begin
    logic [HADDR_W-1:0] a;
    logic [31:0] rd;
    a = '0;
    rd = RD_UNMAPPED;
    nxt_state = cur_ff;
    if (clk_en) begin
      // data phase of a write lands in the port registers
      if (cur_ff.wr_pend) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (cur_ff.wr_addr == 12'(OFS_DATA0 + 12'(p) * OFS_PORT_STRIDE))
            nxt_state.port_data[p] = hwdata[7:0]
              & PAD_EXISTS[p*PORT_BITS +: PORT_BITS];
          if (cur_ff.wr_addr == 12'(OFS_DIR0 + 12'(p) * OFS_PORT_STRIDE))
            nxt_state.port_dir[p] = hwdata[7:0]
              & PAD_EXISTS[p*PORT_BITS +: PORT_BITS];
        end
      end
      nxt_state.wr_pend = 1'b0;
      nxt_state.hreadyout = 1'b1;
      // address phase; reads see a write landing on the same edge
      if (hsel && hready && htrans[1]) begin
        a = haddr;
        nxt_state.wr_pend = hwrite;
        nxt_state.wr_addr = haddr;
        if (!hwrite) begin
          for (int p = 0; p < NUM_PORTS; p++) begin
            if (a == 12'(OFS_DATA0 + 12'(p) * OFS_PORT_STRIDE))
              rd = {24'h00_0000, nxt_state.port_data[p]};
            if (a == 12'(OFS_DIR0 + 12'(p) * OFS_PORT_STRIDE))
              rd = {24'h00_0000, nxt_state.port_dir[p]};
            if (a == 12'(OFS_PIN0 + 12'(p) * OFS_PIN_STRIDE))
              rd = {24'h00_0000, cur_ff.pin[p*PORT_BITS +: PORT_BITS]};
          end
          nxt_state.hrdata = rd;
        end
      end
      // pad sampling for software reads
      nxt_state.pin = pad_gated;
      // pad drive: peripheral first, then port registers
      for (int i = 0; i < NUM_PADS; i++) begin
        if (periph_oe[i]) begin
          nxt_state.pad_oe[i] = 1'b1; // [R07]
          nxt_state.pad_out[i] = periph_val[i]; // [R07]
        end else begin
          nxt_state.pad_oe[i] = nxt_state.port_dir[i/PORT_BITS][i%PORT_BITS]
            & PAD_EXISTS[i]; // [R14]
          nxt_state.pad_out[i] =
            nxt_state.port_data[i/PORT_BITS][i%PORT_BITS]; // [R14]
        end
      end
      // input routing to the peripherals
      for (int c = 0; c < NUM_XFER_CH; c++)
        nxt_state.xfer_req[c] = xfer_req_sel[c]
          & pad_gated[PN_XFER_REQ[c]]; // [R08]
      for (int n = 0; n < NUM_EXT_IRQ; n++)
        nxt_state.irq[n] = ext_irq_en[n]
          & pad_gated[PN_EXT_IRQ0 + 6'(n)]; // [R09]
      nxt_state.conv_trig = converter_ext_trigger_sel
        & pad_gated[PN_CONV_TRIG]; // [R10]
      // receive line idles high when not receiving
      nxt_state.ser_rx = ser_rx_active ? pad_gated[PN_SER_RX] : 1'b1; // [R11]
      // clock input only while the unit does not drive the pad
      nxt_state.ser_clk = ~ser_clk_out_en & pad_gated[PN_SER_CLK]; // [R04]
      for (int t = 0; t < NUM_TIMERS; t++)
        nxt_state.tmr_in[t] = reload_timer_in_en[t]
          & pad_gated[PN_TIMER_IN[t]]; // [R12]
      for (int g = 0; g < NUM_PULSE_TRIG; g++)
        nxt_state.ptrig[g] = pad_gated[PN_PULSE_TRIG0 + 6'(g)];
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur_ff <= '0;
      cur_ff.hreadyout <= 1'b1;
      cur_ff.ser_rx <= 1'b1;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  // outputs straight from the state register, except the constant hresp
  assign hreadyout = cur_ff.hreadyout;
  assign hresp = 1'b0; // okay only, constant
  assign hrdata = cur_ff.hrdata;
  assign pad_out = cur_ff.pad_out;
  assign pad_oe = cur_ff.pad_oe;
  assign xfer_req_in = cur_ff.xfer_req;
  assign ser_rx_data = cur_ff.ser_rx;
  assign ser_clk_in = cur_ff.ser_clk;
  assign reload_timer_in = cur_ff.tmr_in;
  assign pulse_gen_trig_in = cur_ff.ptrig;
  assign converter_ext_trigger = cur_ff.conv_trig;
  assign ext_irq_in = cur_ff.irq;

endmodule // pps_pin_mux

// ===== pps_pin_mux_chk_asserts.sv
// Purpose: checks pad routing and input sampling of the pad mux
// Assumes: routed outputs follow their causes one clock later
// Notes: bound to the mux from the bench top file
`timescale 1ns/1ns
module pps_pin_mux_chk (
  // clock, reset, pads
  input wire logic sys_clk, reset, clk_en, hw_standby_in_n,
  input wire logic [39:0] pad_in, pad_out, pad_oe,
  // peripheral side
  input wire logic [2:0] xfer_ack_out, xfer_ack_out_en, xfer_end_out,
  input wire logic [2:0] xfer_end_out_en, xfer_req_sel, xfer_req_in,
  input wire logic ser_tx_data, ser_tx_en, ser_clk_out, ser_clk_out_en,
  input wire logic ser_clk_in, ser_rx_active, ser_rx_data,
  input wire logic [1:0] reload_timer_out, reload_timer_out_en,
  input wire logic [5:0] pulse_gen_out, pulse_gen_out_en,
  input wire logic [7:0] ext_irq_en, ext_irq_in
);
  import pps_pkg::*;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // transfer channel pads
  for (genvar i = 0; i < 3; i++) begin : g_xf
    chk_ack_drive: assert property (clk_en && xfer_ack_out_en[i] |=>
      pad_oe[PN_XFER_ACK[i]] &&
      pad_out[PN_XFER_ACK[i]] == $past(xfer_ack_out[i]))
      else $error("ack pad wrong");
    chk_end_drive: assert property (clk_en && xfer_end_out_en[i] |=>
      pad_oe[PN_XFER_END[i]] &&
      pad_out[PN_XFER_END[i]] == $past(xfer_end_out[i]))
      else $error("end pad wrong");
    chk_req_sample: assert property (clk_en |=> xfer_req_in[i] ==
      ($past(xfer_req_sel[i]) & $past(pad_in[PN_XFER_REQ[i]])
      & $past(hw_standby_in_n))) else $error("request input wrong");
  end
  // timer and pulse pads
  for (genvar i = 0; i < 2; i++) begin : g_tm
    chk_timer_drive: assert property (
      clk_en && reload_timer_out_en[i] |=>
      pad_oe[PN_TIMER_OUT[i]] &&
      pad_out[PN_TIMER_OUT[i]] == $past(reload_timer_out[i]))
      else $error("timer pad wrong");
  end
  for (genvar i = 0; i < 6; i++) begin : g_pg
    chk_pulse_drive: assert property (clk_en && pulse_gen_out_en[i] |=>
      pad_oe[PN_PULSE_OUT0+i] &&
      pad_out[PN_PULSE_OUT0+i] == $past(pulse_gen_out[i]))
      else $error("pulse pad wrong");
  end
  // serial pads and interrupt inputs
  chk_tx_drive: assert property (clk_en && ser_tx_en |=>
    pad_oe[PN_SER_TX] && pad_out[PN_SER_TX] == $past(ser_tx_data))
    else $error("tx pad wrong");
  chk_sclk_drive: assert property (clk_en && ser_clk_out_en |=>
    pad_oe[PN_SER_CLK] && !ser_clk_in &&
    pad_out[PN_SER_CLK] == $past(ser_clk_out))
    else $error("clock pad wrong");
  chk_rx_sample: assert property (clk_en |=> ser_rx_data ==
    (!$past(ser_rx_active) | ($past(pad_in[27]) & $past(hw_standby_in_n))))
    else $error("rx input wrong");
  chk_irq_sample: assert property (clk_en |=> ext_irq_in ==
    ($past(ext_irq_en) & $past(pad_in[15:8]))) else $error("irq input wrong");
  // main scenarios
  cover property (clk_en && !hw_standby_in_n && xfer_req_sel[0]);
  cover property (ser_clk_out_en && ser_tx_en);
  cover property (ext_irq_in != 8'h00);
endmodule // pps_pin_mux_chk

// ===== pps_board.sv
// Purpose: board circuitry on the shared pads
// Assumes: board drives every pad that the device leaves undriven
// Notes: keeps its own drive off device-driven pads
`timescale 1ns/1ns
module pps_board (
  // pad side
  input wire logic [39:0] pad_out, pad_oe, lvl,
  output logic [39:0] pad_in
);
  // board level only where the device does not drive
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & lvl);
endmodule // pps_board

// ===== peripheral_port_pin_sharing_test.sv
// Purpose: bench for the shared pad multiplexer
// Assumes: zero wait state ahb-lite slave, outputs one clock late
// Notes: hsize held constant; clk_en dropped once to show the freeze
`timescale 1ns/1ns
bind pps_pin_mux pps_pin_mux_chk pps_pin_mux_chk_inst (.*);
module peripheral_port_pin_sharing_test;
  import pps_pkg::*;
  logic sys_clk = 0, reset = 1, clk_en = 1, hsel = 0, hwrite = 0;
  logic hw_standby_in_n = 1, hready, hreadyout, hresp;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic [39:0] pad_in, pad_out, pad_oe, ex, lvl = 40'h5a_c3_96_3c_a5;
  logic [2:0] xfer_ack_out = 3'h2, xfer_ack_out_en = 3'h0, xfer_end_out = 3'h5;
  logic [2:0] xfer_end_out_en = 3'h0, xfer_req_sel = 3'h0, xfer_req_in;
  logic ser_tx_data = 0, ser_tx_en = 0, ser_clk_out = 0, ser_clk_out_en = 0;
  logic ser_rx_active = 0, ser_rx_data, ser_clk_in, converter_ext_trigger;
  logic converter_ext_trigger_sel = 0;
  logic [1:0] reload_timer_out = 2'h1, reload_timer_out_en = 2'h0;
  logic [1:0] reload_timer_in_en = 2'h0, reload_timer_in;
  logic [5:0] pulse_gen_out = 6'h2a, pulse_gen_out_en = 6'h00;
  logic [2:0] pulse_gen_trig_in;
  logic [7:0] ext_irq_en = 8'h00, ext_irq_in;
  int bad_count = 0, check_count = 0;
  pps_pin_mux pps_pin_mux_inst (.*);
  pps_board pps_board_inst (.*);
  assign hready = hreadyout;
  always #20 sys_clk = ~sys_clk;
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      close_out();
    end
  endtask
  // one single word transfer, read data left in q
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // input selects on or off, then compare routed inputs
  task automatic chk_in(input logic on);
    logic [39:0] g;
    xfer_req_sel <= {3{on}};
    ext_irq_en <= {8{on}};
    converter_ext_trigger_sel <= on;
    ser_rx_active <= on;
    reload_timer_in_en <= {2{on}};
    settle();
    g = lvl & (hw_standby_in_n ? ~40'h0 : ~STBY_GATED);
    for (int i = 0; i < 3; i++)
      chk(40'(xfer_req_in[i]), 40'(on & g[PN_XFER_REQ[i]]));
    for (int i = 0; i < 2; i++)
      chk(40'(reload_timer_in[i]), 40'(on & g[PN_TIMER_IN[i]]));
    chk(40'(ext_irq_in), 40'(g[15:8] & {8{on}}));
    chk(40'(converter_ext_trigger), 40'(on & g[PN_CONV_TRIG]));
    chk(40'(pulse_gen_trig_in), 40'(g[3:1]));
    chk(40'(ser_rx_data), 40'(!on | g[PN_SER_RX]));
    chk(40'(ser_clk_in), 40'(g[PN_SER_CLK]));
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int p = 0; p < NUM_PORTS; p++) begin
      bus(0, OFS_DATA0 + 12'(8 * p), 0);
      chk(40'(q), 40'(RST_DATA));
      bus(0, OFS_DIR0 + 12'(8 * p), 0);
      chk(40'(q), 40'(RST_DIR));
      bus(1, OFS_DIR0 + 12'(8 * p), 32'hff);
      bus(1, OFS_DATA0 + 12'(8 * p), 32'hff);
    end
    bus(1, 12'h100, 32'hff);
    bus(0, 12'h100, 0);
    chk(40'(q), 40'(RD_UNMAPPED));
    chk(40'(hresp), 40'h0);
    bus(0, OFS_DATA0, 0);
    chk(40'(q), 40'h0f);
    settle();
    chk(pad_oe, PAD_EXISTS);
    chk(pad_out & PAD_EXISTS, PAD_EXISTS);
    xfer_ack_out_en <= 3'h7;
    xfer_end_out_en <= 3'h7;
    ser_tx_en <= 1'b1;
    ser_clk_out_en <= 1'b1;
    reload_timer_out_en <= 2'h3;
    pulse_gen_out_en <= 6'h3f;
    settle();
    ex = PAD_EXISTS;
    for (int i = 0; i < 3; i++) ex[PN_XFER_ACK[i]] = xfer_ack_out[i];
    for (int i = 0; i < 3; i++) ex[PN_XFER_END[i]] = xfer_end_out[i];
    for (int i = 0; i < 2; i++) ex[PN_TIMER_OUT[i]] = reload_timer_out[i];
    for (int i = 0; i < 6; i++) ex[PN_PULSE_OUT0 + i] = pulse_gen_out[i];
    ex[PN_SER_TX] = ser_tx_data;
    ex[PN_SER_CLK] = ser_clk_out;
    chk(pad_oe, PAD_EXISTS);
    chk(pad_out & PAD_EXISTS, ex);
    chk(40'(ser_clk_in), 40'h0);
    xfer_ack_out_en <= 3'h0;
    xfer_end_out_en <= 3'h0;
    ser_tx_en <= 1'b0;
    ser_clk_out_en <= 1'b0;
    reload_timer_out_en <= 2'h0;
    pulse_gen_out_en <= 6'h00;
    for (int p = 0; p < NUM_PORTS; p++) bus(1, OFS_DIR0 + 12'(8 * p), 0);
    settle();
    chk(pad_oe, 40'h0);
    bus(0, OFS_PIN0 + 12'h4, 0);
    chk(40'(q), 40'(lvl[15:8]));
    chk_in(1'b1);
    hw_standby_in_n <= 1'b0;
    chk_in(1'b1);
    hw_standby_in_n <= 1'b1;
    lvl <= ~lvl;
    chk_in(1'b1);
    // frozen state: neither pads nor enables reach the outputs
    ex = 40'(lvl[15:8]);
    clk_en <= 1'b0;
    lvl <= ~lvl;
    xfer_ack_out_en <= 3'h7;
    settle();
    chk(40'(ext_irq_in), ex);
    chk(pad_oe, 40'h0);
    clk_en <= 1'b1;
    xfer_ack_out_en <= 3'h0;
    chk_in(1'b0);
    close_out();
  end
endmodule // peripheral_port_pin_sharing_test
